// >>> rtl/lpd_pkg.sv
// Shared constants and types for the memory die command core
package lpd_pkg;

    // Timing of the read data path, in picoseconds, and the output delay in system clock cycles
    localparam int MCLK_PS = 10000;
    localparam int DQSCK_PS = 2500;
    localparam int DQSQ_PS = 340;
    localparam int OUT_DLY_RAW = (DQSCK_PS + DQSQ_PS + MCLK_PS - 1) / MCLK_PS;
    localparam int OUT_DLY_CYC = (OUT_DLY_RAW < 1) ? 1 : OUT_DLY_RAW;

    // Read scheduling slots, one per link cycle of latency
    localparam int SLOT_DEPTH = 16;

    // Mode register addresses
    localparam logic [7:0] MA_BURST_CFG = 8'h01;
    localparam logic [7:0] MA_LATENCY = 8'h02;
    localparam logic [7:0] MA_BANK_MASK = 8'h10;
    localparam logic [7:0] MA_SEG_MASK = 8'h11;
    localparam logic [7:0] MA_CAL_A = 8'h20;
    localparam logic [7:0] MA_CAL_B = 8'h28;
    localparam logic [7:0] MA_SOFT_RST = 8'h3F;

    // Values after reset, and the burst length codes
    localparam logic [7:0] SEG_MASK_RST = 8'h00;
    localparam logic [7:0] BANK_MASK_RST = 8'h00;
    localparam logic [2:0] BL_CODE_4 = 3'h2;
    localparam logic [2:0] BL_CODE_8 = 3'h3;
    localparam logic [2:0] BL_CODE_16 = 3'h4;
    localparam logic [2:0] BL_CODE_RST = BL_CODE_4;
    localparam logic [3:0] RL_RST = 4'h3;

    // Beat counts
    localparam logic [4:0] BEATS_4 = 5'h04;
    localparam logic [4:0] BEATS_8 = 5'h08;
    localparam logic [4:0] BEATS_16 = 5'h10;

    // Calibration pattern bytes
    localparam logic [7:0] CAL_A_EVEN = 8'hFF;
    localparam logic [7:0] CAL_A_ODD = 8'h00;
    localparam logic [7:0] CAL_B_LO = 8'h00;
    localparam logic [7:0] CAL_B_HI = 8'hFF;

    typedef enum logic [2:0]
    {
        CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_MRW, CMD_MRR, CMD_OTHER
    } lpd_cmd_t;

    typedef enum logic [1:0] {SRC_ARRAY, SRC_MR, SRC_CAL_A, SRC_CAL_B} lpd_src_t;

    typedef enum logic [1:0] {RD_IDLE = 2'b00, RD_PRE = 2'b01, RD_BURST = 2'b11} lpd_rd_st_t;

    typedef struct packed
    {
        logic valid;
        logic [4:0] len;
        lpd_src_t src;
        logic [2:0] bank;
        logic [12:0] row;
        logic [8:0] col;
        logic [7:0] mr_val;
    } lpd_rd_req_t;

    typedef struct packed
    {
        logic [31:0] dq;
        logic dq_oe_n;
        logic dqs;
        logic dqs_oe_n;
    } lpd_pins_t;

endpackage : lpd_pkg

// >>> rtl/lpd_rd_burst.sv
// Read burst scheduler, data strobe generator and output delay line
`timescale 1ns/1ps
module lpd_rd_burst (
    input wire logic mclk, // system clock
    input wire logic reset, // async reset, active high
    input wire logic rise_p, // link clock rising edge seen
    input wire logic fall_p, // link clock falling edge seen
    input wire lpd_pkg::lpd_rd_req_t req, // read request, valid for one cycle
    input wire logic [3:0] rl, // read latency in link cycles
    output lpd_pkg::lpd_pins_t pins_o // delayed data and strobe pins
);

    lpd_pkg::lpd_rd_req_t slot_r [lpd_pkg::SLOT_DEPTH];
    lpd_pkg::lpd_rd_req_t cur_r;
    lpd_pkg::lpd_rd_st_t st_r;
    logic [4:0] beat_r;
    logic [3:0] idx;
    lpd_pkg::lpd_pins_t pins_now;
    lpd_pkg::lpd_pins_t dly_r [lpd_pkg::OUT_DLY_CYC];

    function automatic logic [31:0] rd_word(input lpd_pkg::lpd_rd_req_t r, input logic [4:0] b);
        case (r.src)
            lpd_pkg::SRC_ARRAY: rd_word = {7'h00, r.bank, r.row, 9'(r.col + {4'h0, b})};
            lpd_pkg::SRC_CAL_A: rd_word = {24'h000000, b[0] ? lpd_pkg::CAL_A_ODD : lpd_pkg::CAL_A_EVEN};
            lpd_pkg::SRC_CAL_B: rd_word = {24'h000000, b[1] ? lpd_pkg::CAL_B_HI : lpd_pkg::CAL_B_LO};
            default: rd_word = {24'h000000, r.mr_val};
        endcase
    endfunction : rd_word

    assign idx = (rl == 4'h0) ? 4'h0 : 4'(rl - 4'h1);

    ////////////////////////////////////////////////////////////////////////////////
    // Latency slots shift on each link rising edge
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < lpd_pkg::SLOT_DEPTH; i++)
            begin
                slot_r[i] <= '0;
            end
        end
        else
        begin
            if (rise_p)
            begin
                for (int i = 0; i < lpd_pkg::SLOT_DEPTH - 1; i++)
                begin
                    slot_r[i] <= slot_r[i + 1];
                end
                slot_r[lpd_pkg::SLOT_DEPTH - 1] <= '0;
            end
            if (req.valid)
            begin
                slot_r[idx] <= req; // [RULE19]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Burst sequencing, one beat per link edge
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            st_r <= lpd_pkg::RD_IDLE;
            cur_r <= '0;
            beat_r <= 5'h00;
        end
        else if (rise_p)
        begin
            if (slot_r[0].valid)
            begin
                st_r <= lpd_pkg::RD_BURST; // [RULE19]
                cur_r <= slot_r[0];
                beat_r <= 5'h00;
            end
            else if (st_r == lpd_pkg::RD_BURST && 5'(beat_r + 5'h01) < cur_r.len)
            begin
                beat_r <= 5'(beat_r + 5'h01); // [RULE21]
            end
            else if (slot_r[1].valid)
            begin
                st_r <= lpd_pkg::RD_PRE; // [RULE20]
            end
            else
            begin
                st_r <= lpd_pkg::RD_IDLE;
            end
        end
        else if (fall_p && st_r == lpd_pkg::RD_BURST && 5'(beat_r + 5'h01) < cur_r.len)
        begin
            beat_r <= 5'(beat_r + 5'h01); // [RULE22]
        end
    end

    always_comb
    begin
        pins_now.dq = (st_r == lpd_pkg::RD_BURST) ? rd_word(cur_r, beat_r) : 32'h00000000;
        pins_now.dq_oe_n = (st_r != lpd_pkg::RD_BURST);
        pins_now.dqs = (st_r == lpd_pkg::RD_BURST) ? ~beat_r[0] : 1'b0; // [RULE20]
        pins_now.dqs_oe_n = (st_r == lpd_pkg::RD_IDLE);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Clock-to-strobe and strobe-to-data delay
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < lpd_pkg::OUT_DLY_CYC; i++)
            begin
                dly_r[i] <= '{dq: 32'h00000000, dq_oe_n: 1'b1, dqs: 1'b0, dqs_oe_n: 1'b1};
            end
        end
        else
        begin
            dly_r[0] <= pins_now; // [RULE19]
            for (int i = 1; i < lpd_pkg::OUT_DLY_CYC; i++)
            begin
                dly_r[i] <= dly_r[i - 1];
            end
        end
    end

    assign pins_o = dly_r[lpd_pkg::OUT_DLY_CYC - 1];

    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    a_preamble_low: assert property (st_r == lpd_pkg::RD_PRE |-> !pins_now.dqs_oe_n && !pins_now.dqs
        && pins_now.dq_oe_n) else $error("strobe preamble not low"); // [RULE20]
    a_first_beat_edge: assert property (rise_p && slot_r[0].valid |=> beat_r == 5'h00
        && pins_now.dqs && !pins_now.dq_oe_n) else $error("first beat not on rising strobe"); // [RULE20]
    a_burst_full_len: assert property ($fell(st_r == lpd_pkg::RD_BURST) |->
        $past(beat_r) == 5'($past(cur_r.len) - 5'h01)) else $error("burst ended short"); // [RULE21]
    a_beat_len_legal: assert property (st_r == lpd_pkg::RD_BURST |-> cur_r.len == lpd_pkg::BEATS_4
        || cur_r.len == lpd_pkg::BEATS_8 || cur_r.len == lpd_pkg::BEATS_16)
        else $error("illegal burst length"); // [RULE22]
    a_pin_delay: assert property (pins_o == $past(pins_now, lpd_pkg::OUT_DLY_CYC))
        else $error("output delay wrong"); // [RULE19]
    c_read_interrupt: cover property (rise_p && slot_r[0].valid && st_r == lpd_pkg::RD_BURST);

endmodule : lpd_rd_burst

// >>> rtl/lpd_sdram_core.sv
// Command decode, bank tracking and mode registers of the memory die
//
// Operation
// [RULE1] Segment mask is write-only, 8 bits; a one blocks refresh, reset zero.
// [RULE2] Mask bit n governs rows whose top three address bits equal n.
// [RULE3] Mode register read of 20h returns calibration pattern A.
// [RULE4] Mode register read of 28h returns calibration pattern B.
// [RULE5] Reset register 3Fh is write-only, operand ignored; controller never reads it.
// [RULE6] Controller avoids all reserved, do-not-use and vendor mode register addresses.
// [RULE7] Chip select low, bit0 low, bit1 high on rising edge means activate.
// [RULE8] Activate opens the addressed row in the addressed bank.
// [RULE9] Controller activates first and waits activate-to-access delay before access.
// [RULE10] Controller precharges before reactivating; same-bank activates obey row cycle time.
// [RULE11] Controller spaces activates to different banks by the different-bank delay.
// [RULE12] Controller issues at most four activations per rolling four-activate window.
// [RULE13] Four-activate window in cycles is window time over clock period, rounded up.
// [RULE14] Controller waits the longer all-bank precharge time after precharge-all.
// [RULE15] Controller holds a newly registered clock-gate level for its minimum pulse.
// [RULE16] Chip select low, bit0 high, bit1 low is access; bit2 picks read.
// [RULE17] Controller interrupts only 8/16 bursts, same direction, even cycles, spacing met.
// [RULE18] Start column comes from rising bits 5-6 and falling bits 1-9; the code takes falling bits 1-6 only.
// [RULE19] First read datum follows read latency plus strobe and data delays.
// [RULE20] Strobe is driven low one preamble, then beats align to strobe edges.
// [RULE21] One read command yields a full burst on successive cycles.
// [RULE22] A burst has 4, 8 or 16 beats as programmed.
// [RULE23] Bank mask at 10h blocks refresh per bank; zero after reset.
// [RULE24] Track open state and row per bank; flag activate/precharge ordering faults.
// [RULE25] Controller tracks all activate and precharge timing before issuing commands.
`timescale 1ns/1ps
module lpd_sdram_core (
    input wire logic mclk, // system clock, 100 MHz
    input wire logic reset, // async reset, active high
    input wire logic ck, // link clock pin
    input wire logic cke, // clock-gate pin
    input wire logic cs_n, // chip select pin, active low
    input wire logic [9:0] cmd_addr_bus, // double-rate command/address pins
    input wire logic [31:0] dq_i, // data pins, input side
    output logic [31:0] dq_o, // data pins, driven value
    output logic dq_oe_n, // data pins, low while driven
    input wire logic dqs_i, // strobe pin, input side
    output logic dqs_o, // strobe pin, driven value
    output logic dqs_oe_n, // strobe pin, low while driven
    input wire logic [2:0] refr_bank, // bank of a refresh query
    input wire logic [12:0] refr_row, // row of a refresh query
    output logic refr_allow, // refresh permitted for the queried row
    output logic [7:0] bank_open, // banks currently open
    output logic cmd_error // one-cycle pulse on an ordering fault
);

    logic [2:0] ck_s;
    logic [1:0] cke_s;
    logic [1:0] cs_s;
    logic [9:0] ca_s1;
    logic [9:0] ca_s2;
    logic rise_p;
    logic fall_p;
    logic pend_r;
    logic [9:0] rise_r;
    logic cmd_v;
    lpd_pkg::lpd_cmd_t cmd_typ;
    logic [7:0] ma;
    logic [7:0] op;
    logic [2:0] bank;
    logic [12:0] row;
    logic [8:0] col;
    logic [7:0] seg_mask_r;
    logic [7:0] bank_mask_r;
    logic [2:0] bl_r;
    logic [3:0] rl_r;
    logic [7:0] open_r;
    logic [12:0] row_r [8];
    logic err_r;
    logic refr_allow_r;
    lpd_pkg::lpd_rd_req_t req;
    lpd_pkg::lpd_pins_t pins;

    function automatic lpd_pkg::lpd_cmd_t decode(input logic [9:0] r);
        if (r[1:0] == 2'h2)
        begin
            decode = lpd_pkg::CMD_ACT; // [RULE7]
        end
        else if (r[1:0] == 2'h1)
        begin
            decode = r[2] ? lpd_pkg::CMD_RD : lpd_pkg::CMD_WR; // [RULE16]
        end
        else if (r[3:0] == 4'hB)
        begin
            decode = lpd_pkg::CMD_PRE;
        end
        else if (r[3:0] == 4'h0)
        begin
            decode = lpd_pkg::CMD_MRW;
        end
        else if (r[3:0] == 4'h8)
        begin
            decode = lpd_pkg::CMD_MRR;
        end
        else
        begin
            decode = lpd_pkg::CMD_OTHER;
        end
    endfunction : decode

    function automatic logic [4:0] bl_beats(input logic [2:0] code);
        case (code)
            lpd_pkg::BL_CODE_8: bl_beats = lpd_pkg::BEATS_8;
            lpd_pkg::BL_CODE_16: bl_beats = lpd_pkg::BEATS_16;
            default: bl_beats = lpd_pkg::BEATS_4;
        endcase
    endfunction : bl_beats

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and link edge detection
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            ck_s <= 3'h0;
            cke_s <= 2'h0;
            cs_s <= 2'h3;
            ca_s1 <= 10'h000;
            ca_s2 <= 10'h000;
        end
        else
        begin
            ck_s <= {ck_s[1:0], ck};
            cke_s <= {cke_s[0], cke};
            cs_s <= {cs_s[0], cs_n};
            ca_s1 <= cmd_addr_bus;
            ca_s2 <= ca_s1;
        end
    end

    assign rise_p = ck_s[1] & ~ck_s[2];
    assign fall_p = ~ck_s[1] & ck_s[2];

    ////////////////////////////////////////////////////////////////////////////////
    // Command capture: rising half, then falling half completes it
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            pend_r <= 1'b0;
            rise_r <= 10'h000;
        end
        else if (rise_p)
        begin
            pend_r <= ~cs_s[1] & cke_s[1]; // [RULE7]
            rise_r <= ca_s2;
        end
        else if (fall_p)
        begin
            pend_r <= 1'b0;
        end
    end

    assign cmd_v = fall_p & pend_r;
    assign cmd_typ = cmd_v ? decode(rise_r) : lpd_pkg::CMD_NOP;
    assign ma = {ca_s2[1:0], rise_r[9:4]};
    assign op = ca_s2[9:2];
    assign bank = rise_r[9:7]; // [RULE8]
    assign row = {rise_r[6:2], ca_s2[7:0]}; // [RULE8]
    assign col = {ca_s2[6:1], rise_r[6:5], 1'b0}; // [RULE18]

    ////////////////////////////////////////////////////////////////////////////////
    // Mode registers; reserved addresses are ignored
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            seg_mask_r <= lpd_pkg::SEG_MASK_RST;
            bank_mask_r <= lpd_pkg::BANK_MASK_RST;
            bl_r <= lpd_pkg::BL_CODE_RST;
            rl_r <= lpd_pkg::RL_RST;
        end
        else if (cmd_typ == lpd_pkg::CMD_MRW)
        begin
            case (ma)
                lpd_pkg::MA_SEG_MASK: seg_mask_r <= op; // [RULE1]
                lpd_pkg::MA_BANK_MASK: bank_mask_r <= op; // [RULE23]
                lpd_pkg::MA_BURST_CFG: bl_r <= op[2:0]; // [RULE22]
                lpd_pkg::MA_LATENCY: rl_r <= op[3:0]; // [RULE19]
                lpd_pkg::MA_SOFT_RST:
                begin
                    seg_mask_r <= lpd_pkg::SEG_MASK_RST; // [RULE5]
                    bank_mask_r <= lpd_pkg::BANK_MASK_RST;
                    bl_r <= lpd_pkg::BL_CODE_RST;
                    rl_r <= lpd_pkg::RL_RST;
                end
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bank state and ordering faults
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            open_r <= 8'h00;
            for (int i = 0; i < 8; i++)
            begin
                row_r[i] <= 13'h0000;
            end
        end
        else if (cmd_typ == lpd_pkg::CMD_ACT)
        begin
            open_r[bank] <= 1'b1; // [RULE24]
            row_r[bank] <= row; // [RULE8]
        end
        else if (cmd_typ == lpd_pkg::CMD_PRE)
        begin
            if (rise_r[4])
            begin
                open_r <= 8'h00;
            end
            else
            begin
                open_r[bank] <= 1'b0;
            end
        end
        else if (cmd_typ == lpd_pkg::CMD_MRW && ma == lpd_pkg::MA_SOFT_RST)
        begin
            open_r <= 8'h00; // [RULE5]
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            err_r <= 1'b0;
        end
        else
        begin
            err_r <= (cmd_typ == lpd_pkg::CMD_ACT && open_r[bank]) // [RULE24]
                || ((cmd_typ == lpd_pkg::CMD_RD || cmd_typ == lpd_pkg::CMD_WR)
                && !open_r[bank]) // [RULE9]
                || (cmd_typ == lpd_pkg::CMD_MRR && ma == lpd_pkg::MA_SOFT_RST); // [RULE5]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Refresh permission from the bank and segment masks
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            refr_allow_r <= 1'b0;
        end
        else
        begin
            refr_allow_r <= ~seg_mask_r[refr_row[12:10]] // [RULE2]
                & ~bank_mask_r[refr_bank]; // [RULE23]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read requests for array and mode register reads
    always_comb
    begin
        req = '0;
        req.valid = (cmd_typ == lpd_pkg::CMD_RD) || (cmd_typ == lpd_pkg::CMD_MRR);
        req.bank = bank;
        req.row = row_r[bank];
        req.col = col;
        if (cmd_typ == lpd_pkg::CMD_RD)
        begin
            req.len = bl_beats(bl_r); // [RULE21]
            req.src = lpd_pkg::SRC_ARRAY;
        end
        else
        begin
            req.len = lpd_pkg::BEATS_4;
            req.src = lpd_pkg::SRC_MR;
            case (ma)
                lpd_pkg::MA_CAL_A: req.src = lpd_pkg::SRC_CAL_A; // [RULE3]
                lpd_pkg::MA_CAL_B: req.src = lpd_pkg::SRC_CAL_B; // [RULE4]
                lpd_pkg::MA_BURST_CFG: req.mr_val = {5'h00, bl_r};
                lpd_pkg::MA_LATENCY: req.mr_val = {4'h0, rl_r};
                default: req.src = lpd_pkg::SRC_MR;
            endcase
        end
    end

    lpd_rd_burst u_rd (
        .mclk(mclk),
        .reset(reset),
        .rise_p(rise_p),
        .fall_p(fall_p),
        .req(req),
        .rl(rl_r),
        .pins_o(pins)
    );

    assign dq_o = pins.dq;
    assign dq_oe_n = pins.dq_oe_n;
    assign dqs_o = pins.dqs;
    assign dqs_oe_n = pins.dqs_oe_n;
    assign refr_allow = refr_allow_r;
    assign bank_open = open_r;
    assign cmd_error = err_r;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    a_seg_mask_wr: assert property (cmd_typ == lpd_pkg::CMD_MRW && ma == lpd_pkg::MA_SEG_MASK
        |=> seg_mask_r == $past(op)) else $error("segment mask not written"); // [RULE1]
    a_seg_select: assert property (seg_mask_r[refr_row[12:10]] |=> !refr_allow)
        else $error("masked segment allowed refresh"); // [RULE2]
    a_bank_mask_blk: assert property (bank_mask_r[refr_bank] |=> !refr_allow)
        else $error("masked bank allowed refresh"); // [RULE23]
    a_cal_a_read: assert property (cmd_typ == lpd_pkg::CMD_MRR && ma == lpd_pkg::MA_CAL_A
        |-> req.valid && req.src == lpd_pkg::SRC_CAL_A) else $error("pattern A not chosen"); // [RULE3]
    a_cal_b_read: assert property (cmd_typ == lpd_pkg::CMD_MRR && ma == lpd_pkg::MA_CAL_B
        |-> req.valid && req.src == lpd_pkg::SRC_CAL_B) else $error("pattern B not chosen"); // [RULE4]
    a_soft_reset: assert property (cmd_typ == lpd_pkg::CMD_MRW && ma == lpd_pkg::MA_SOFT_RST
        |=> open_r == 8'h00 && seg_mask_r == lpd_pkg::SEG_MASK_RST) else $error("reset missed"); // [RULE5]
    a_act_decode: assert property (cmd_v && rise_r[1:0] == 2'h2 |=> open_r[$past(bank)])
        else $error("activate not decoded"); // [RULE7]
    a_act_row: assert property (cmd_typ == lpd_pkg::CMD_ACT |=> row_r[$past(bank)] == $past(row))
        else $error("wrong row opened"); // [RULE8]
    a_rd_decode: assert property (cmd_v && rise_r[2:0] == 3'h5 |-> req.valid
        && req.src == lpd_pkg::SRC_ARRAY && req.col == col) else $error("read not decoded"); // [RULE16]
    a_order_fault: assert property (cmd_typ == lpd_pkg::CMD_ACT && open_r[bank] |=> cmd_error)
        else $error("double activate not flagged"); // [RULE24]
    c_activate: cover property (cmd_typ == lpd_pkg::CMD_ACT);
    c_array_read: cover property (cmd_typ == lpd_pkg::CMD_RD && open_r[bank]);
    c_cal_read: cover property (cmd_typ == lpd_pkg::CMD_MRR && ma == lpd_pkg::MA_CAL_A);

endmodule : lpd_sdram_core

// >>> bench/lpd_ctrl_model.sv
// Controller model driving the link command pins
`timescale 1ns/1ps
module lpd_ctrl_model (
    output logic ck, // link clock, free running
    output logic cke, // clock gate
    output logic cs_n, // chip select, active low
    output logic [9:0] ca, // command/address pins
    output realtime t_cmd // time of last command rising edge
);
    initial
    begin
        ck = 1'b0;
        cke = 1'b1;
        cs_n = 1'b1;
        ca = 10'h000;
        t_cmd = 0;
    end
    always #80 ck = ~ck;
    ////////////////////////////////////////
    // Pins move mid-phase, clear of the sampling edges; idle bus is inverted
    task automatic cmd(input logic [9:0] r, input logic [9:0] f);
        @(negedge ck);
        #50 cs_n = 1'b0;
        ca = r;
        @(posedge ck);
        t_cmd = $realtime;
        #50 ca = f;
        @(negedge ck);
        #50 cs_n = 1'b1;
        ca = ~f;
    endtask : cmd
endmodule : lpd_ctrl_model

// >>> bench/lpd_sdram_core_tb.sv
// Self-checking bench for the memory die command core
`timescale 1ns/1ps
module lpd_sdram_core_tb;
    logic mclk = 1'b0;
    logic reset, ck, cke, cs_n, dq_oe_n, dqs_o, dqs_oe_n, refr_allow, cmd_error;
    logic prev_oe, prev_dqs, pre_ok;
    logic [9:0] ca;
    logic [2:0] refr_bank, b;
    logic [12:0] refr_row, r;
    logic [31:0] dq_o;
    logic [7:0] bank_open, sm, bm;
    logic [8:0] c;
    realtime t_cmd, t_beat;
    logic [31:0] beats[$];
    int num_errors = 0, cmp_count = 0, err_seen = 0, e, rl;
    always #5 mclk = ~mclk;
    lpd_ctrl_model ctl (.ck(ck), .cke(cke), .cs_n(cs_n), .ca(ca), .t_cmd(t_cmd));
    lpd_sdram_core dut (.mclk(mclk), .reset(reset), .ck(ck), .cke(cke), .cs_n(cs_n),
        .cmd_addr_bus(ca), .dq_i(32'h0000_0000), .dq_o(dq_o), .dq_oe_n(dq_oe_n),
        .dqs_i(1'b0), .dqs_o(dqs_o), .dqs_oe_n(dqs_oe_n), .refr_bank(refr_bank),
        .refr_row(refr_row), .refr_allow(refr_allow), .bank_open(bank_open),
        .cmd_error(cmd_error));
    ////////////////////////////////////////
    task automatic check(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1)
        begin
            num_errors++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : check
    task automatic tally_and_finish();
        if (num_errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    // Collects beats on each strobe change while data is driven
    always @(negedge mclk)
    begin
        if (cmd_error === 1'b1)
            err_seen++;
        if (dq_oe_n === 1'b0 && (prev_oe !== 1'b0 || dqs_o !== prev_dqs))
        begin
            if (prev_oe !== 1'b0)
            begin
                t_beat = $realtime;
                check(dqs_o === 1'b1 && pre_ok, "preamble");
            end
            beats.push_back(dq_o);
        end
        prev_oe = dq_oe_n;
        prev_dqs = dqs_o;
        pre_ok = dqs_oe_n === 1'b0 && dqs_o === 1'b0;
    end
    task automatic mode_reg_write(input logic [7:0] a, input logic [7:0] op);
        ctl.cmd({a[5:0], 4'h0}, {op, a[7:6]});
    endtask : mode_reg_write
    task automatic refr(input logic [2:0] qb, input logic [12:0] qr, input logic x);
        @(negedge mclk);
        refr_bank = qb;
        refr_row = qr;
        repeat (2) @(negedge mclk);
        check(refr_allow === x, "refresh allow");
    endtask : refr
    task automatic burst(input logic [9:0] ri, input logic [9:0] fa, input int n);
        beats.delete();
        ctl.cmd(ri, fa);
        repeat ((rl + n) * 16 + 20) @(posedge mclk);
        check(beats.size() == n, "beat count");
        if (n > 0)
            check(t_beat - t_cmd > rl * 160 + 10 && t_beat - t_cmd < rl * 160 + 70, "lat");
    endtask : burst
    ////////////////////////////////////////
    initial
    begin
        reset = 1'b1;
        refr_bank = 3'h0;
        refr_row = 13'h0000;
        rl = 3;
        void'($urandom(88));
        repeat (10) @(negedge mclk);
        reset = 1'b0;
        check(bank_open === 8'h00 && dq_oe_n === 1'b1 && dqs_oe_n === 1'b1, "reset");
        refr(3'h0, 13'h1C00, 1'b1);
        sm = $urandom;
        bm = $urandom;
        mode_reg_write(8'h11, sm);
        mode_reg_write(8'h10, bm);
        for (int i = 0; i < 8; i++)
        begin
            b = $urandom;
            r = $urandom;
            r[12:10] = i;
            refr(b, r, ~sm[i] & ~bm[b]);
        end
        b = $urandom;
        r = $urandom;
        c = {$urandom, 1'b0};
        ctl.cmd({b, r[12:8], 2'b10}, {2'h0, r[7:0]});
        check(bank_open[b] === 1'b1, "activate");
        e = err_seen;
        ctl.cmd({b, r[12:8], 2'b10}, {2'h0, r[7:0]});
        check(err_seen == e + 1, "reactivate");
        for (int k = 0; k < 3; k++)
        begin
            rl = 2 + $urandom % 5;
            mode_reg_write(8'h01, 8'h02 + k);
            mode_reg_write(8'h02, rl[7:0]);
            burst({b, c[2:1], 5'h05}, {3'h0, c[8:3], 1'b0}, 4 << k);
            for (int i = 0; i < (4 << k); i++)
                check(beats[i] === {7'h00, b, r, 9'(c + i)}, "read data");
        end
        burst({6'h20, 4'h8}, 10'h000, 4);
        check({beats[0][7:0], beats[1][7:0], beats[2][7:0], beats[3][7:0]} === 32'hFF00_FF00, "pa");
        burst({6'h28, 4'h8}, 10'h000, 4);
        check({beats[0][7:0], beats[1][7:0], beats[2][7:0], beats[3][7:0]} === 32'h0000_FFFF, "pb");
        burst({6'h02, 4'h8}, 10'h000, 4);
        check(beats[3] === 32'(rl), "latency readback");
        e = err_seen;
        burst({6'h3F, 4'h8}, 10'h000, 4);
        burst({b + 3'h1, c[2:1], 5'h05}, {3'h0, c[8:3], 1'b0}, 16);
        check(err_seen == e + 2, "bad reads");
        burst({b, c[2:1], 5'h01}, 10'h000, 0);
        @(negedge mclk);
        cke = 1'b0;
        ctl.cmd({b + 3'h2, 7'h02}, 10'h000);
        check(bank_open[b + 3'h2] === 1'b0, "gated");
        repeat (48) @(negedge mclk);
        cke = 1'b1;
        ctl.cmd({b + 3'h2, 7'h02}, 10'h000);
        ctl.cmd({b, 7'h0B}, 10'h000);
        check(bank_open[b] === 1'b0 && bank_open[b + 3'h2] === 1'b1, "precharge");
        ctl.cmd({b, 7'h1B}, 10'h000);
        check(bank_open === 8'h00, "precharge all");
        ctl.cmd({b, 7'h02}, 10'h000);
        mode_reg_write(8'h3F, $urandom);
        check(bank_open === 8'h00, "soft reset");
        refr(b, r, 1'b1);
        tally_and_finish();
    end
    initial
    begin
        #300000;
        num_errors++;
        tally_and_finish();
    end
endmodule : lpd_sdram_core_tb
